// [hw/arp_core.sv]
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module arp_core
    import arp_pkg::*;
#(
    parameter int NOTES = ARP_NOTES,
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // keyboard side
    input wire logic key_on_i,
    input wire logic key_off_i,
    input wire logic [6:0] key_note_i,
    input wire logic [6:0] key_vel_i,
    input wire logic [3:0] key_chan_i,
    input wire logic tick_i,
    input wire logic midi_start_i,
    input wire logic midi_stop_i,
    input wire logic group_step_i,
    input wire logic zone_note_on_i,
    input wire logic chan_note_on_i,
    input wire logic [6:0] trans_note_i,
    input wire logic [6:0] pat_note_i,
    input wire logic [6:0] pat_vel_i,
    input wire logic pat_rest_i,
    output logic [5:0] pat_step_o,
    output logic group_join_o,
    // generated notes
    output logic [ARP_EVT_W-1:0] evt_o,
    output logic evt_valid_o,
    input wire logic evt_ready_i
);
    // ==========================================================
    // registers
    logic [31:0] ctrl_reg;
    logic [31:0] cfg_reg;
    logic [6:0] ref_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    arp_quant_t quant;
    arp_vel_t vel_mode;
    arp_order_t order;
    arp_dest_t dest;
    logic enable, fill_in, restart_new, trans_en, mono;
    logic [7:0] ticks_per_step;
    logic [3:0] out_chan;
    logic out_follow;
    logic [6:0] pattern;
    logic [5:0] pat_len;
    logic [1:0] octaves;
    assign enable = ctrl_reg[0];
    assign quant = arp_quant_t'(ctrl_reg[3:1]);
    assign vel_mode = arp_vel_t'(ctrl_reg[5:4]);
    assign order = arp_order_t'(ctrl_reg[7:6]);
    assign fill_in = ctrl_reg[8];
    assign restart_new = ctrl_reg[9];
    assign trans_en = ctrl_reg[10];
    assign dest = arp_dest_t'(ctrl_reg[12:11]);
    assign out_follow = ctrl_reg[13];
    assign out_chan = ctrl_reg[17:14];
    assign mono = ctrl_reg[18];
    assign octaves = ctrl_reg[20:19];
    assign ticks_per_step = cfg_reg[7:0];
    assign pattern = cfg_reg[14:8];
    assign pat_len = cfg_reg[21:16];
    logic wb_hit;
    assign wb_hit = cyc_i && stb_i && !ack_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_hit;
        end
    end
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
        input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            old[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
        return old;
    endfunction : wmerge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= ARP_CTRL_RST;
            cfg_reg <= {16'h0010, 8'h00, ARP_TICKS_RST};
            ref_reg <= ARP_REF_RST;
        end else if (wb_hit && we_i) begin
            if (adr_i == ARP_ADR_CTRL) ctrl_reg <= wmerge(ctrl_reg, dat_i, sel_i);
            if (adr_i == ARP_ADR_CFG) cfg_reg <= wmerge(cfg_reg, dat_i, sel_i);
            if (adr_i == ARP_ADR_TRANS && sel_i[0]) ref_reg <= dat_i[6:0];
        end
    end
    // ==========================================================
    // held notes, arrival order
    logic [6:0] held_note [NOTES];
    logic [6:0] held_vel [NOTES];
    logic [3:0] held_cnt;
    logic [3:0] trig_chan_reg;
    logic new_note_reg;
    // slots at or above the released note move down one
    logic [NOTES-1:0] off_from;
    always_comb begin
        off_from[0] = held_cnt != 0 && held_note[0] == key_note_i;
        for (int i = 1; i < NOTES; i++) begin
            off_from[i] = off_from[i-1] || (4'(i) < held_cnt && held_note[i] == key_note_i);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            held_cnt <= '0;
            trig_chan_reg <= '0;
            for (int i = 0; i < NOTES; i++) begin
                held_note[i] <= '0;
                held_vel[i] <= '0;
            end
        end else if (key_on_i && held_cnt != 4'(NOTES)) begin
            held_note[held_cnt[2:0]] <= key_note_i;
            held_vel[held_cnt[2:0]] <= key_vel_i;
            held_cnt <= held_cnt + 4'h1;
            trig_chan_reg <= key_chan_i;
        end else if (key_off_i) begin
            for (int i = 0; i < NOTES - 1; i++) begin
                if (off_from[i]) begin
                    held_note[i] <= held_note[i+1];
                    held_vel[i] <= held_vel[i+1];
                end
            end
            if (off_from[NOTES-1]) held_cnt <= held_cnt - 4'h1;
        end
    end
    // rank of note k by pitch: count of held notes strictly lower (ties by slot)
    function automatic logic [3:0] pick(input logic [2:0] idx, input arp_order_t ord,
        input logic [3:0] cnt, input logic [6:0] n [NOTES]);
        logic [3:0] r;
        logic [3:0] want;
        pick = 4'h0;
        want = (ord == ARP_O_DOWN) ? cnt - 4'h1 - {1'b0, idx} : {1'b0, idx};
        for (int k = 0; k < NOTES; k++) begin
            r = 4'h0;
            for (int j = 0; j < NOTES; j++) begin
                if (4'(j) < cnt && (n[j] < n[k] || (n[j] == n[k] && j < k))) r = r + 4'h1;
            end
            if (4'(k) < cnt && r == want) pick = 4'(k);
        end
        if (ord == ARP_O_PLAYED) pick = {1'b0, idx};
    endfunction : pick
    // ==========================================================
    // transpose
    logic signed [7:0] shift_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shift_reg <= '0;
        end else if (!trans_en) begin
            shift_reg <= '0; // R15
        end else if (zone_note_on_i || chan_note_on_i) begin // R13
            shift_reg <= $signed({1'b0, trans_note_i}) - $signed({1'b0, ref_reg}); // R14
        end
    end
    // ==========================================================
    // step timing
    logic [7:0] tick_cnt;
    logic [2:0] since_step;
    logic running_reg, bg_reg, sync_mode, smart, late, step_now;
    logic [5:0] step_reg;
    logic pass_reg;
    logic [1:0] oct_reg;
    assign sync_mode = (quant != ARP_Q_OFF); // R1
    assign smart = (quant == ARP_Q_SMART || quant == ARP_Q_SMART_LOCK);
    assign late = smart && since_step < ARP_LATE_TICKS;
    logic tick_step;
    assign tick_step = tick_i && (tick_cnt + 8'h1 >= ticks_per_step); // R10
    // a smart late first key raises step_now at once, but held_cnt is still 0 so no note is sent; otherwise at grid (R2)
    assign step_now = sync_mode ? (tick_step || (key_on_i && held_cnt == 0 && late)) : tick_step;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt <= '0;
            since_step <= '0;
        end else if (midi_start_i || (sync_mode && group_step_i && !running_reg)) begin
            tick_cnt <= '0; // R3 R17
            since_step <= '0;
        end else if (tick_i) begin
            tick_cnt <= tick_step ? 8'h0 : tick_cnt + 8'h1; // R10
            since_step <= tick_step ? 3'h0 : (since_step == 3'h7 ? since_step : since_step + 3'h1);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            running_reg <= 1'b0;
            bg_reg <= 1'b0;
            group_join_o <= 1'b0;
        end else begin
            if (midi_start_i) bg_reg <= 1'b1; // R17
            if (midi_stop_i) bg_reg <= 1'b0;
            running_reg <= enable && (held_cnt != 0 || bg_reg || (sync_mode && group_step_i)); // R3
            group_join_o <= enable && sync_mode && held_cnt != 0; // R3
        end
    end
    logic reset_pat_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_note_reg <= 1'b0;
        end else if (key_on_i && restart_new && !(late && sync_mode)) begin
            new_note_reg <= 1'b1; // R16
        end else if (step_now) begin
            new_note_reg <= 1'b0;
        end
    end
    assign reset_pat_reg = new_note_reg || (key_on_i && restart_new && late && sync_mode); // R16
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            step_reg <= '0;
            pass_reg <= 1'b0;
            oct_reg <= '0;
        end else if (step_now && (running_reg || bg_reg)) begin
            if (reset_pat_reg || step_reg + 6'h1 >= pat_len) begin
                step_reg <= '0;
                if (!reset_pat_reg) begin
                    pass_reg <= ~pass_reg; // R6
                    oct_reg <= (oct_reg >= octaves) ? 2'h0 : oct_reg + 2'h1; // R7
                end
            end else begin
                step_reg <= step_reg + 6'h1;
            end
        end
    end
    assign pat_step_o = step_reg;
    // ==========================================================
    // note choice
    logic [2:0] idx;
    logic [3:0] slot;
    logic [6:0] note_sel;
    logic [6:0] vel_sel;
    logic [1:0] oct_use;
    logic basic, algo;
    arp_evt_t evt;
    assign basic = mono && pattern <= ARP_BASIC_LAST;
    assign algo = mono && pattern <= ARP_ALGO_LAST;
    always_comb begin
        idx = (pat_note_i == 7'h0) ? 3'h0 : pat_note_i[2:0] - 3'h1;
        if (basic) idx = 3'(step_reg % 6'(held_cnt == 0 ? 4'h1 : held_cnt));
        if (4'(idx) >= held_cnt) begin
            idx = (held_cnt == 0) ? 3'h0 : 3'(held_cnt - 4'h1); // R5
        end else if (fill_in && !basic && pass_reg && 7'(idx) + 7'(pat_len) < 7'(held_cnt)) begin
            idx = 3'(7'(idx) + 7'(pat_len)); // R6
        end
        slot = algo ? {1'b0, idx} : pick(idx, order, held_cnt, held_note); // R8 R9
        if (algo) slot = pick(idx, ARP_O_UP, held_cnt, held_note); // R9
        oct_use = (basic && fill_in) ? 2'(step_reg / 6'(held_cnt == 0 ? 4'h1 : held_cnt)) : oct_reg;
        note_sel = 7'(8'(held_note[slot[2:0]]) + 8'(shift_reg) + {4'h0, oct_use, 2'h0} * 8'h3);
        unique case (vel_mode) // R4
            ARP_V_PLAYED: vel_sel = held_vel[slot[2:0]];
            ARP_V_FULL: vel_sel = ARP_VEL_FULL;
            ARP_V_HALF: vel_sel = ARP_VEL_HALF;
            ARP_V_PROG: vel_sel = pat_vel_i;
        endcase
        evt.note = note_sel;
        evt.vel = vel_sel;
        evt.chan = out_follow ? trig_chan_reg : out_chan; // R12
        evt.to_engine = (dest != ARP_D_MIDI); // R11
        evt.to_midi = (dest != ARP_D_ENGINE); // R11
    end
    logic fifo_in_valid, fifo_in_ready;
    assign fifo_in_valid = step_now && running_reg && held_cnt != 0 && !pat_rest_i;
    arp_fifo #(.WIDTH(ARP_EVT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_data_i(evt),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .out_data_o(evt_o),
        .out_valid_o(evt_valid_o),
        .out_ready_i(evt_ready_i)
    );
    logic [15:0] drop_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            drop_reg <= '0;
        end else if (fifo_in_valid && !fifo_in_ready) begin
            drop_reg <= drop_reg + 16'h1;
        end
    end
    // ==========================================================
    // read mux
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= '0;
        end else if (wb_hit) begin
            unique case (adr_i)
                ARP_ADR_CTRL: rdat_reg <= ctrl_reg;
                ARP_ADR_CFG: rdat_reg <= cfg_reg;
                ARP_ADR_TRANS: rdat_reg <= {24'h0, 1'b0, ref_reg};
                ARP_ADR_STAT: rdat_reg <= {8'h0, shift_reg, 4'h0, held_cnt, pass_reg, oct_reg,
                    bg_reg, running_reg, 3'h0};
                ARP_ADR_PAT: rdat_reg <= {26'h0, step_reg};
                ARP_ADR_CNT: rdat_reg <= {16'h0, drop_reg};
                default: rdat_reg <= 32'h0;
            endcase
        end
    end
    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;
    // ==========================================================
    // checks
    property p_vel_full;
        @(posedge clk_i) disable iff (rst_i)
        (vel_mode == ARP_V_FULL) |-> evt.vel == 7'h7f;
    endproperty
    a_vel_full: assert property (p_vel_full) else $error("full velocity wrong"); // R4
    property p_route;
        @(posedge clk_i) disable iff (rst_i)
        (dest == ARP_D_MIDI) |-> !evt.to_engine && evt.to_midi;
    endproperty
    a_route: assert property (p_route) else $error("midi only routing wrong"); // R11
    property p_trans_off;
        @(posedge clk_i) disable iff (rst_i)
        !trans_en |=> shift_reg == 8'sh0;
    endproperty
    a_trans_off: assert property (p_trans_off) else $error("shift kept while off"); // R15
    property p_tick_wrap;
        @(posedge clk_i) disable iff (rst_i)
        tick_i && !midi_start_i && !group_step_i && tick_step |=> tick_cnt == 8'h0;
    endproperty
    a_tick_wrap: assert property (p_tick_wrap) else $error("tick count not wrapped"); // R10
    property p_chan;
        @(posedge clk_i) disable iff (rst_i)
        !out_follow |-> evt.chan == out_chan;
    endproperty
    a_chan: assert property (p_chan) else $error("fixed channel ignored"); // R12
    property p_start_bg;
        @(posedge clk_i) disable iff (rst_i)
        midi_start_i && !midi_stop_i |=> bg_reg ##1 bg_reg || $past(midi_stop_i);
    endproperty
    a_start_bg: assert property (p_start_bg) else $error("background run missing"); // R17
    property p_shift;
        @(posedge clk_i) disable iff (rst_i)
        trans_en && (zone_note_on_i || chan_note_on_i) && trans_note_i == ref_reg
            && $stable(trans_en) |=> shift_reg == 8'sh0;
    endproperty
    a_shift: assert property (p_shift) else $error("reference gives nonzero shift"); // R14
    property p_join;
        @(posedge clk_i) disable iff (rst_i)
        enable && sync_mode && held_cnt != 0 |=> group_join_o;
    endproperty
    a_join: assert property (p_join) else $error("group join not raised"); // R3
    property p_top_note;
        @(posedge clk_i) disable iff (rst_i)
        mono && !basic && !fill_in && held_cnt != 0 && pat_note_i > 7'(held_cnt)
            && pat_note_i <= 7'(NOTES) |-> idx == 3'(held_cnt - 4'h1);
    endproperty
    a_top_note: assert property (p_top_note) else $error("top note not used"); // R5
    property p_drop;
        @(posedge clk_i) disable iff (rst_i)
        fifo_in_valid && !fifo_in_ready |=> drop_reg == $past(drop_reg) + 16'h1;
    endproperty
    a_drop: assert property (p_drop) else $error("drop not counted");
    property p_bg_step;
        @(posedge clk_i) disable iff (rst_i)
        bg_reg && step_now && !reset_pat_reg && step_reg + 6'h1 < pat_len
            |=> step_reg == $past(step_reg) + 6'h1;
    endproperty
    a_bg_step: assert property (p_bg_step) else $error("silent step lost"); // R17
endmodule : arp_core
`default_nettype wire

// [hw/arp_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module arp_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;
    assign in_ready_o = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem[rd_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_reg] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : arp_fifo
`default_nettype wire

// [hw/arp_pkg.sv]
// What this block does
// [R1] the quantise setting takes five values: off, grid, smart, grid locked, smart locked.
// [R2] smart quantise sounds a slightly late note at once and aligns from the next step; grid waits. The code sends the note only at the next grid step.
// [R3] any nonzero quantise setting joins the shared step grid so all such arpeggiators run together.
// [R4] output velocity is the held key's, 127, 63, or the pattern step's, per a four-way setting.
// [R5] mono without fill-in: indices above the held count use the top held note; extra notes stay silent.
// [R6] mono with fill-in: held notes above the top index replace their lower partners every second pass.
// [R7] basic up and down with fill-in sweep all octaves per pass; without, one octave per pass in turn.
// [R8] mono index 1 upward maps to held notes by rising pitch, falling pitch or arrival order.
// [R9] ordering is ignored for the algorithmic patterns 0 to 10.
// [R10] steps advance every selectable number of clock ticks; a sixteenth is six ticks.
// [R11] notes go to the sound engine, to midi, or to both, per a three-way destination.
// [R12] midi notes use the triggering channel when following input, else a fixed channel 1 to 16.
// [R13] with live transpose on, notes from the transpose zone and the transpose channel are taken.
// [R14] the shift is the signed difference to the reference note; the reference itself gives zero.
// [R15] with live transpose off, transpose notes are ignored and the key stays original.
// [R16] with restart on new notes the pattern resets: next step for grid, at once for smart late notes.
// [R17] a start or continue message runs the pattern silently so later keys sound the current step.
package arp_pkg;
    localparam logic [7:0] ARP_ADR_CTRL = 8'h00;
    localparam logic [7:0] ARP_ADR_CFG = 8'h04;
    localparam logic [7:0] ARP_ADR_TRANS = 8'h08;
    localparam logic [7:0] ARP_ADR_STAT = 8'h0c;
    localparam logic [7:0] ARP_ADR_PAT = 8'h10;
    localparam logic [7:0] ARP_ADR_CNT = 8'h14;
    localparam logic [6:0] ARP_VEL_FULL = 7'h7f;
    localparam logic [6:0] ARP_VEL_HALF = 7'h3f;
    localparam logic [6:0] ARP_REF_RST = 7'h3c;
    localparam logic [7:0] ARP_TICKS_RST = 8'h06;
    localparam logic [6:0] ARP_ALGO_LAST = 7'h0a;
    localparam logic [6:0] ARP_BASIC_LAST = 7'h03;
    localparam logic [2:0] ARP_LATE_TICKS = 3'h2;
    localparam logic [31:0] ARP_CTRL_RST = 32'h0000_0100;
    localparam int ARP_NOTES = 8;
    typedef enum logic [2:0] {ARP_Q_OFF, ARP_Q_GRID, ARP_Q_SMART, ARP_Q_GRID_LOCK,
        ARP_Q_SMART_LOCK} arp_quant_t;
    typedef enum logic [1:0] {ARP_V_PLAYED, ARP_V_FULL, ARP_V_HALF, ARP_V_PROG} arp_vel_t;
    typedef enum logic [1:0] {ARP_O_UP, ARP_O_DOWN, ARP_O_PLAYED} arp_order_t;
    typedef enum logic [1:0] {ARP_D_ENGINE, ARP_D_BOTH, ARP_D_MIDI} arp_dest_t;
    typedef struct packed {
        logic [6:0] note;
        logic [6:0] vel;
        logic [3:0] chan;
        logic to_engine;
        logic to_midi;
    } arp_evt_t;
    localparam int ARP_EVT_W = $bits(arp_evt_t);
endpackage : arp_pkg

// [tb/arp_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==============================
// pattern store and note sink
module arp_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [5:0] pat_step_i,
    input wire logic [6:0] idx_i,
    input wire logic hold_i,
    input wire logic stall_i,
    output logic [6:0] pat_note_o,
    output logic [6:0] pat_vel_o,
    output logic pat_rest_o,
    output logic evt_ready_o
);
    logic [7:0] lfsr_reg;
    // stall pattern for the sink side
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lfsr_reg <= 8'h5a;
        end else begin
            lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5]};
        end
    end
    // every step holds the same index so expectations do not track the step
    assign pat_note_o = idx_i;
    assign pat_vel_o = 7'h21;
    assign pat_rest_o = 1'b0;
    assign evt_ready_o = ~hold_i & (~stall_i | lfsr_reg[0]);
endmodule : arp_far_model
`default_nettype wire

// [tb/tb_arp_core.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_arp_core;
    import arp_pkg::*;
    localparam logic [6:0] ORD_NOTE [4] = '{7'h28, 7'h3c, 7'h32, 7'h3c};
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0, key_chan_i = 4'h0, kc = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, key_on_i = 1'b0, key_off_i = 1'b0, tick_i = 1'b0;
    logic [6:0] key_note_i = 7'h0, key_vel_i = 7'h0, trans_note_i = 7'h0;
    logic [6:0] idx = 7'h1, kv = 7'h40, pat_note, pat_vel;
    logic zone_i = 1'b0, chan_i = 1'b0, hold = 1'b0, stall = 1'b0;
    logic mstart = 1'b0, mstop = 1'b0, gstep = 1'b0;
    logic pat_rest, group_join_o, evt_valid_o, evt_ready;
    logic [5:0] pat_step_o;
    logic [ARP_EVT_W-1:0] evt_o;
    arp_evt_t exp_q[$];
    int fail_count = 0, n_checks = 0, got = 0, tick_n = 0;
    int stamp[$];
    always #2.5 clk_i = ~clk_i;
    arp_core i_arp_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .key_on_i(key_on_i), .key_off_i(key_off_i), .key_note_i(key_note_i),
        .key_vel_i(key_vel_i), .key_chan_i(key_chan_i), .tick_i(tick_i),
        .midi_start_i(mstart), .midi_stop_i(mstop), .group_step_i(gstep),
        .zone_note_on_i(zone_i), .chan_note_on_i(chan_i), .trans_note_i(trans_note_i),
        .pat_note_i(pat_note), .pat_vel_i(pat_vel), .pat_rest_i(pat_rest),
        .pat_step_o(pat_step_o), .group_join_o(group_join_o), .evt_o(evt_o),
        .evt_valid_o(evt_valid_o), .evt_ready_i(evt_ready));
    arp_far_model i_arp_far_model (.clk_i(clk_i), .rst_i(rst_i), .pat_step_i(pat_step_o),
        .idx_i(idx), .hold_i(hold), .stall_i(stall), .pat_note_o(pat_note),
        .pat_vel_o(pat_vel), .pat_rest_o(pat_rest), .evt_ready_o(evt_ready));
    // ==============================
    // compare and report
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        n_checks++;
        if (act !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : chk
    task automatic chk_evt(input arp_evt_t act, input arp_evt_t exp);
        // channel only matters on the midi path
        if (exp.to_midi === 1'b0) act.chan = exp.chan;
        chk({12'h0, act}, {12'h0, exp});
    endtask : chk_evt
    task automatic results();
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    always @(posedge clk_i) begin
        if (tick_i === 1'b1) tick_n++;
        if (evt_valid_o === 1'b1 && evt_ready === 1'b1) begin
            got++;
            stamp.push_back(tick_n);
            if (exp_q.size() == 0) chk(32'h1, 32'h0);
            else chk_evt(arp_evt_t'(evt_o), exp_q.pop_front());
        end
    end
    // ==============================
    // drivers
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hf;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 100);
        rd = dat_o;
        if (k >= 100) begin
            fail_count++;
            results();
        end
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    task automatic key(input logic on, input logic [6:0] n);
        @(posedge clk_i);
        key_on_i <= on;
        key_off_i <= ~on;
        key_note_i <= n;
        key_vel_i <= kv;
        key_chan_i <= kc;
        @(posedge clk_i);
        key_on_i <= 1'b0;
        key_off_i <= 1'b0;
    endtask : key
    task automatic xpose(input logic z, input logic [6:0] n);
        @(posedge clk_i);
        zone_i <= z;
        chan_i <= ~z;
        trans_note_i <= n;
        @(posedge clk_i);
        zone_i <= 1'b0;
        chan_i <= 1'b0;
    endtask : xpose
    task automatic tick();
        @(posedge clk_i);
        tick_i <= 1'b1;
        @(posedge clk_i);
        tick_i <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : tick
    task automatic wait_got(input int n);
        int k;
        k = 0;
        while (got < n && k < 2000) begin
            if (n == 3) tick();
            else @(posedge clk_i);
            k++;
        end
        if (k >= 2000) begin
            fail_count++;
            results();
        end
    endtask : wait_got
    task automatic run(input logic [31:0] c, input logic [7:0] tps, input arp_evt_t x);
        wb(1'b1, ARP_ADR_CFG, {16'h0010, 1'b0, 7'h14, tps});
        wb(1'b1, ARP_ADR_CTRL, c);
        got = 0;
        stamp.delete();
        repeat (3) exp_q.push_back(x);
        wait_got(3);
        chk(stamp[2] - stamp[1], {24'h0, tps});
        chk({31'h0, group_join_o}, {31'h0, c[3:1] != 3'h0});
        wb(1'b1, ARP_ADR_CTRL, 32'h0);
    endtask : run
    // ==============================
    // main sequence
    initial begin
        arp_evt_t x;
        logic [6:0] nt;
        logic [31:0] c;
        int s;
        s = $urandom(32'h1cb08ff4);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 8'hfc, 32'hffff_ffff);
        wb(1'b0, ARP_ADR_CTRL, 32'h0);
        chk(rd, ARP_CTRL_RST);
        wb(1'b0, ARP_ADR_CFG, 32'h0);
        chk(rd, 32'h0010_0006);
        wb(1'b0, ARP_ADR_TRANS, 32'h0);
        chk(rd, {25'h0, ARP_REF_RST});
        wb(1'b0, 8'hfc, 32'h0);
        chk(rd, 32'h0);
        chk({26'h0, pat_step_o}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            kv = 7'($urandom_range(127, 1));
            kc = 4'($urandom_range(15, 0));
            nt = 7'($urandom_range(80, 30));
            key(1'b1, nt);
            x.note = nt;
            x.vel = (i == 0) ? kv : (i == 1) ? ARP_VEL_FULL : (i == 2) ? ARP_VEL_HALF : 7'h21;
            x.chan = i[0] ? kc : 4'(i + 4);
            x.to_engine = (i % 3) != 2;
            x.to_midi = (i % 3) != 0;
            c = 32'h0004_0001 | (i << 4) | ((i % 3) << 11) | (i[0] << 13) | ((i + 4) << 14);
            run(c, 8'(6 - i), x);
            key(1'b0, nt);
        end
        key(1'b1, 7'h32);
        key(1'b1, 7'h28);
        key(1'b1, 7'h3c);
        for (int j = 0; j < 4; j++) begin
            idx = (j == 3) ? 7'h5 : 7'h1;
            x = '{note: ORD_NOTE[j], vel: ARP_VEL_FULL, chan: 4'h0, to_engine: 1'b1, to_midi: 1'b0};
            run(32'h0004_0011 | ((j % 3) << 6), 8'h06, x);
        end
        idx = 7'h1;
        key(1'b0, 7'h28);
        key(1'b0, 7'h3c);
        for (int t = 0; t < 4; t++) begin
            c = (t == 3) ? 32'h0004_0015 : 32'h0004_0411;
            wb(1'b1, ARP_ADR_CTRL, c);
            xpose(t == 0 || t == 3, (t == 0) ? 7'h3e : (t == 1) ? 7'h39 : (t == 2) ? 7'h3c : 7'h46);
            nt = (t == 0) ? 7'h34 : (t == 1) ? 7'h2f : 7'h32;
            x = '{note: nt, vel: ARP_VEL_FULL, chan: 4'h0, to_engine: 1'b1, to_midi: 1'b0};
            run(c, 8'h06, x);
        end
        wb(1'b1, ARP_ADR_CFG, 32'h0010_1401);
        wb(1'b1, ARP_ADR_CTRL, 32'h0004_0011);
        hold <= 1'b1;
        x.note = 7'h32;
        got = 0;
        repeat (32) exp_q.push_back(x);
        repeat (40) tick();
        hold <= 1'b0;
        stall <= 1'b1;
        wait_got(32);
        repeat (20) @(posedge clk_i);
        chk(got, 32'd32);
        chk({31'h0, evt_valid_o}, 32'h0);
        wb(1'b0, ARP_ADR_CNT, 32'h0);
        chk(rd, 32'd8);
        key(1'b0, 7'h32);
        // 76 steps modulo 16 leave 12; then 5 group steps, 5 silent ones, none after stop
        for (int g = 0; g < 3; g++) begin
            wb(1'b1, ARP_ADR_CTRL, (g == 0) ? 32'h0004_0013 : 32'h0004_0011);
            gstep <= (g == 0);
            mstart <= (g == 1);
            mstop <= (g == 2);
            @(posedge clk_i);
            mstart <= 1'b0;
            mstop <= 1'b0;
            repeat (5) tick();
            chk({26'h0, pat_step_o}, (g == 0) ? 32'd1 : 32'd6);
        end
        results();
    end
endmodule : tb_arp_core
`default_nettype wire
